// ===== core/iocm_defs.vh
`ifndef IOCM_DEFS_VH
`define IOCM_DEFS_VH
// line geometry: 16-byte lines, 4 longwords
`define IOCM_AW          32
`define IOCM_DW          32
`define IOCM_LINES       128
`define IOCM_IDX_W       7
`define IOCM_IDX_LSB     4
`define IOCM_IDX_MSB     10
`define IOCM_WORD_LSB    2
`define IOCM_WORD_MSB    3
`define IOCM_TAG_LSB     11
`define IOCM_TAG_W       21
`define IOCM_WORDS       4
`define IOCM_WSEL_W      2
`define IOCM_WSEL_LAST   2'h3
// mapper: 8 pages of 8 MB (64 MB span)
`define IOCM_MAP_ENTRIES 8
`define IOCM_MAP_SEL_W   3
`define IOCM_PAGE_LSB    23
`define IOCM_PAGE_MSB    25
`define IOCM_XLAT_W      9
`define IOCM_XLAT_LSB    23
`define IOCM_DT_W        2
`define IOCM_DT_INVALID  2'h1
// system enable bit positions
`define IOCM_EN_W        4
`define IOCM_EN_CENTRAL  0
`define IOCM_EN_IOC      1
`define IOCM_EN_DIRECT   2
`define IOCM_EN_LOOP     3
`endif

// ===== core/iocm_ram.v
`timescale 1ns/100ps
`default_nettype none
module iocm_ram #(
    parameter AW = 9,
    parameter DW = 32
) (
    // clock
    input  wire          clk,
    // write port
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    // read port
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ===== core/iocm_core.v
`timescale 1ns/100ps
`default_nettype none
`include "iocm_defs.vh"
module iocm_core (
    // clock and reset
    input  wire                          clk,
    input  wire                          reset_n,
    // system enable register
    input  wire                          sys_en_we,
    input  wire [`IOCM_EN_W-1:0]         sys_en_wdata,
    output wire [`IOCM_EN_W-1:0]         system_enable_register,
    // mapper programming
    input  wire                          map_we,
    input  wire [`IOCM_MAP_SEL_W-1:0]    map_sel,
    input  wire [`IOCM_XLAT_W-1:0]       map_xlat,
    input  wire [`IOCM_DT_W-1:0]         map_page_data_type,
    input  wire                          map_cache_en,
    input  wire                          map_wr_protect,
    // direct access request
    input  wire                          req_valid,
    output wire                          req_ready,
    input  wire                          req_write,
    input  wire                          req_flush,
    input  wire [`IOCM_AW-1:0]           req_addr,
    input  wire [`IOCM_DW-1:0]           req_wdata,
    output reg                           rsp_valid_r,
    output reg  [`IOCM_DW-1:0]           rsp_rdata_r,
    output reg                           rsp_violation_r,
    // system memory port, one longword per mem_ack
    output reg                           mem_req_r,
    output reg                           mem_write_r,
    output reg  [`IOCM_AW-1:0]           mem_addr_r,
    output reg  [`IOCM_DW-1:0]           mem_wdata_r,
    input  wire                          mem_ack,
    input  wire [`IOCM_DW-1:0]           mem_rdata,
    // status
    output wire                          busy
);
    localparam [5:0] ST_IDLE = 6'h01, ST_LOOK = 6'h02, ST_WB = 6'h04,
                     ST_FILL = 6'h08, ST_MEM = 6'h10, ST_DONE = 6'h20;

    reg  [1:0] rst_sync_r;
    wire       rst_n = rst_sync_r[1];
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) rst_sync_r <= 2'h0;
        else rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    reg [`IOCM_EN_W-1:0] sys_en_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) sys_en_r <= {`IOCM_EN_W{1'b0}};
        else if (sys_en_we) sys_en_r <= sys_en_wdata;
    end
    assign system_enable_register = sys_en_r;

    reg [`IOCM_XLAT_W-1:0] map_xlat_r [0:`IOCM_MAP_ENTRIES-1];
    reg [`IOCM_DT_W-1:0]   map_dt_r   [0:`IOCM_MAP_ENTRIES-1];
    reg [`IOCM_MAP_ENTRIES-1:0] map_ce_r;
    reg [`IOCM_MAP_ENTRIES-1:0] map_wp_r;
    genvar g;
    generate
        for (g = 0; g < `IOCM_MAP_ENTRIES; g = g + 1) begin : g_map
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    map_xlat_r[g] <= {`IOCM_XLAT_W{1'b0}};
                    map_dt_r[g]   <= `IOCM_DT_INVALID;
                    map_ce_r[g]   <= 1'b0;
                    map_wp_r[g]   <= 1'b0;
                end else if (map_we && map_sel == g) begin
                    map_xlat_r[g] <= map_xlat;
                    map_dt_r[g]   <= map_page_data_type;
                    map_ce_r[g]   <= map_cache_en;
                    map_wp_r[g]   <= map_wr_protect;
                end
            end
        end
    endgenerate

    function [`IOCM_AW-1:0] xlate;
        input [`IOCM_AW-1:0]     a;
        input [`IOCM_XLAT_W-1:0] x;
        begin
            xlate = {x, a[`IOCM_XLAT_LSB-1:0]};
        end
    endfunction

    // tag store
    reg [`IOCM_TAG_W-1:0]  tag_r   [0:`IOCM_LINES-1];
    reg [`IOCM_LINES-1:0]  valid_r;
    reg [`IOCM_LINES-1:0]  dirty_r;
    reg [`IOCM_LINES-1:0]  vwp_r;
    integer i;

    // captured request
    reg [5:0]              st_r;
    reg                    wr_r, fl_r;
    reg [`IOCM_AW-1:0]     addr_r;
    reg [`IOCM_DW-1:0]     wd_r;
    reg [`IOCM_WSEL_W-1:0] wcnt_r;
    reg                    rd_pend_r;

    wire [`IOCM_IDX_W-1:0]    idx  = addr_r[`IOCM_IDX_MSB:`IOCM_IDX_LSB];
    wire [`IOCM_MAP_SEL_W-1:0] pg  = addr_r[`IOCM_PAGE_MSB:`IOCM_PAGE_LSB];
    wire [`IOCM_AW-1:0]       paddr = xlate(addr_r, map_xlat_r[pg]);
    wire [`IOCM_TAG_W-1:0]    ptag = paddr[`IOCM_AW-1:`IOCM_TAG_LSB];
    wire hit      = valid_r[idx] && tag_r[idx] == ptag;
    wire vdirty   = valid_r[idx] && dirty_r[idx];
    wire cache_on = sys_en_r[`IOCM_EN_IOC] && map_ce_r[pg];
    wire pg_bad   = map_dt_r[pg] == `IOCM_DT_INVALID;
    wire [`IOCM_AW-1:0] vaddr = {tag_r[idx], idx,
                                 {`IOCM_IDX_LSB{1'b0}}};

    // data array
    reg                         ram_we;
    reg  [`IOCM_IDX_W+1:0]      ram_wa;
    reg  [`IOCM_DW-1:0]         ram_wd;
    reg  [`IOCM_IDX_W+1:0]      ram_ra;
    wire [`IOCM_DW-1:0]         ram_rd;
    iocm_ram #(.AW(`IOCM_IDX_W + 2), .DW(`IOCM_DW)) u_data (
        .clk   (clk),
        .we    (ram_we),
        .waddr (ram_wa),
        .wdata (ram_wd),
        .raddr (ram_ra),
        .rdata (ram_rd)
    );

    assign req_ready = st_r == ST_IDLE && sys_en_r[`IOCM_EN_DIRECT];
    assign busy      = st_r != ST_IDLE;
    wire [`IOCM_WSEL_W-1:0] word_sel = addr_r[`IOCM_WORD_MSB:`IOCM_WORD_LSB];

    always @* begin
        ram_we = 1'b0;
        ram_wa = {idx, word_sel};
        ram_wd = wd_r;
        ram_ra = {idx, wcnt_r};
        if (st_r == ST_LOOK) ram_ra = {idx, word_sel};
        if (st_r == ST_FILL && mem_ack) begin
            ram_we = 1'b1;
            ram_wa = {idx, wcnt_r};
            ram_wd = (wr_r && wcnt_r == word_sel) ? wd_r : mem_rdata;
        end else if (st_r == ST_LOOK && cache_on && hit && wr_r && !fl_r && !pg_bad) begin
            ram_we = 1'b1;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            wr_r <= 1'b0;
            fl_r <= 1'b0;
            addr_r <= {`IOCM_AW{1'b0}};
            wd_r <= {`IOCM_DW{1'b0}};
            wcnt_r <= {`IOCM_WSEL_W{1'b0}};
            rd_pend_r <= 1'b0;
            valid_r <= {`IOCM_LINES{1'b0}};
            dirty_r <= {`IOCM_LINES{1'b0}};
            vwp_r <= {`IOCM_LINES{1'b0}};
            for (i = 0; i < `IOCM_LINES; i = i + 1) tag_r[i] <= {`IOCM_TAG_W{1'b0}};
            rsp_valid_r <= 1'b0;
            rsp_rdata_r <= {`IOCM_DW{1'b0}};
            rsp_violation_r <= 1'b0;
            mem_req_r <= 1'b0;
            mem_write_r <= 1'b0;
            mem_addr_r <= {`IOCM_AW{1'b0}};
            mem_wdata_r <= {`IOCM_DW{1'b0}};
        end else begin
            rsp_valid_r <= 1'b0;
            rd_pend_r <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    if (req_valid && req_ready) begin
                        wr_r <= req_write | req_flush;
                        fl_r <= req_flush;
                        addr_r <= req_addr;
                        wd_r <= req_wdata;
                        st_r <= ST_LOOK;
                    end
                end
                ST_LOOK: begin
                    wcnt_r <= {`IOCM_WSEL_W{1'b0}};
                    if (pg_bad && !wr_r) begin
                        rsp_violation_r <= 1'b1;
                        rsp_rdata_r <= {`IOCM_DW{1'b0}};
                        st_r <= ST_DONE;
                    end else if (fl_r) begin
                        if (vdirty && !vwp_r[idx]) st_r <= ST_WB;
                        else begin
                            valid_r[idx] <= 1'b0;
                            dirty_r[idx] <= 1'b0;
                            rsp_violation_r <= 1'b0;
                            st_r <= ST_DONE;
                        end
                    end else if (!cache_on) begin
                        mem_req_r <= 1'b1;
                        mem_write_r <= wr_r;
                        mem_addr_r <= paddr;
                        mem_wdata_r <= wd_r;
                        st_r <= ST_MEM;
                    end else if (hit) begin
                        if (wr_r) dirty_r[idx] <= 1'b1;
                        rd_pend_r <= !wr_r;
                        rsp_violation_r <= 1'b0;
                        st_r <= ST_DONE;
                    end else if (vdirty && !vwp_r[idx]) begin
                        st_r <= ST_WB;
                    end else begin
                        st_r <= ST_FILL;
                        mem_req_r <= 1'b1;
                        mem_write_r <= 1'b0;
                        mem_addr_r <= {paddr[`IOCM_AW-1:`IOCM_IDX_LSB], {`IOCM_IDX_LSB{1'b0}}};
                    end
                end
                ST_WB: begin
                    if (!mem_req_r) begin
                        rd_pend_r <= 1'b1;
                        if (rd_pend_r) begin
                            rd_pend_r <= 1'b0;
                            mem_req_r <= 1'b1;
                            mem_write_r <= 1'b1;
                            mem_addr_r <= vaddr + {wcnt_r, {`IOCM_WORD_LSB{1'b0}}};
                            mem_wdata_r <= ram_rd;
                        end
                    end else if (mem_ack) begin
                        mem_req_r <= 1'b0;
                        wcnt_r <= wcnt_r + 1'b1;
                        if (wcnt_r == `IOCM_WSEL_LAST) begin
                            dirty_r[idx] <= 1'b0;
                            wcnt_r <= {`IOCM_WSEL_W{1'b0}};
                            if (fl_r) begin
                                valid_r[idx] <= 1'b0;
                                rsp_violation_r <= 1'b0;
                                st_r <= ST_DONE;
                            end else begin
                                st_r <= ST_FILL;
                                mem_req_r <= 1'b1;
                                mem_write_r <= 1'b0;
                                mem_addr_r <= {paddr[`IOCM_AW-1:`IOCM_IDX_LSB],
                                               {`IOCM_IDX_LSB{1'b0}}};
                            end
                        end
                    end
                end
                ST_FILL: begin
                    if (mem_ack) begin
                        if (!wr_r && wcnt_r == word_sel)
                            rsp_rdata_r <= mem_rdata;
                        wcnt_r <= wcnt_r + 1'b1;
                        mem_addr_r <= mem_addr_r + {{(`IOCM_AW-3){1'b0}}, 3'h4};
                        if (wcnt_r == `IOCM_WSEL_LAST) begin
                            mem_req_r <= 1'b0;
                            tag_r[idx] <= ptag;
                            valid_r[idx] <= 1'b1;
                            dirty_r[idx] <= wr_r;
                            vwp_r[idx] <= map_wp_r[pg];
                            rsp_violation_r <= 1'b0;
                            st_r <= ST_DONE;
                        end
                    end
                end
                ST_MEM: begin
                    if (mem_ack) begin
                        mem_req_r <= 1'b0;
                        mem_write_r <= 1'b0;
                        rsp_rdata_r <= wr_r ? {`IOCM_DW{1'b0}} : mem_rdata;
                        rsp_violation_r <= 1'b0;
                        st_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    mem_write_r <= 1'b0;
                    if (rd_pend_r) rsp_rdata_r <= ram_rd;
                    rsp_valid_r <= 1'b1;
                    st_r <= ST_IDLE;
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== tb/iocm_core_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "iocm_defs.vh"
module iocm_core_properties (
    // clock, reset and controls
    input wire logic        clk, reset_n, sys_en_we, map_we, map_cache_en,
    input wire logic        req_valid, req_ready, req_write, req_flush, busy,
    input wire logic        rsp_valid_r, rsp_violation_r, mem_req_r, mem_write_r, mem_ack,
    input wire logic [3:0]  sys_en_wdata, system_enable_register,
    input wire logic [2:0]  map_sel,
    input wire logic [8:0]  map_xlat,
    input wire logic [1:0]  map_page_data_type,
    // data and addresses
    input wire logic [31:0] req_addr, req_wdata, rsp_rdata_r, mem_addr_r, mem_wdata_r, mem_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // mapper mirror and captured request
    reg [8:0]  xlat_m [0:7];
    reg [7:0]  ce_m, inv_m;
    reg        c_w_r, c_byp_r;
    reg [31:0] c_exp_r, c_wd_r;
    wire       hs = req_valid && req_ready;
    wire [2:0] pg = req_addr[25:23];
    always @(posedge clk) begin
        if (map_we) xlat_m[map_sel] <= map_xlat;
    end
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ce_m <= 8'h00; inv_m <= 8'hFF; c_w_r <= 1'b0; c_byp_r <= 1'b0;
            c_exp_r <= 32'h0; c_wd_r <= 32'h0;
        end else begin
            if (map_we) begin
                ce_m[map_sel] <= map_cache_en;
                inv_m[map_sel] <= (map_page_data_type == `IOCM_DT_INVALID);
            end
            if (hs) begin
                c_w_r <= req_write;
                c_byp_r <= !system_enable_register[`IOCM_EN_IOC] || !ce_m[pg];
                c_exp_r <= {xlat_m[pg], req_addr[22:0]};
                c_wd_r <= req_wdata;
            end
        end
    end
    sequence s_take_byp;
        hs && !req_flush && !inv_m[pg] && (!system_enable_register[`IOCM_EN_IOC] || !ce_m[pg]);
    endsequence
    sequence s_mem_go;
        ##[1:3] (mem_req_r && mem_addr_r == c_exp_r && mem_write_r == c_w_r
                 && (!c_w_r || mem_wdata_r == c_wd_r));
    endsequence
    property p_en_load;
        sys_en_we |=> system_enable_register == $past(sys_en_wdata);
    endproperty
    a_en_load: assert property (p_en_load) else $error("enable register not loaded");
    property p_ready_gate;
        req_ready |-> system_enable_register[`IOCM_EN_DIRECT] && !busy;
    endproperty
    a_ready_gate: assert property (p_ready_gate) else $error("ready while busy or path off");
    property p_rsp_pulse;
        rsp_valid_r |=> !rsp_valid_r;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("response longer than one cycle");
    property p_hs_busy;
        hs |=> busy;
    endproperty
    a_hs_busy: assert property (p_hs_busy) else $error("not busy after request");
    property p_mem_hold;
        mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r) && $stable(mem_write_r)
            && $stable(mem_wdata_r);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped early");
    property p_bypass_addr;
        s_take_byp |-> s_mem_go;
    endproperty
    a_bypass_addr: assert property (p_bypass_addr) else $error("bypass access wrong");
    property p_viol;
        hs && !req_write && !req_flush && inv_m[pg] |=>
            !mem_req_r throughout (##[0:3] (rsp_valid_r && rsp_violation_r));
    endproperty
    a_viol: assert property (p_viol) else $error("invalid page read not refused");
    property p_byp_data;
        mem_ack && mem_req_r && !mem_write_r && c_byp_r |=>
            ##1 (rsp_valid_r && rsp_rdata_r == $past(mem_rdata, 2));
    endproperty
    a_byp_data: assert property (p_byp_data) else $error("bypass read data wrong");
    property p_wr_noviol;
        rsp_valid_r && c_w_r |-> !rsp_violation_r;
    endproperty
    a_wr_noviol: assert property (p_wr_noviol) else $error("write flagged as violation");
endmodule
bind iocm_core iocm_core_properties u_props (.*);
`default_nettype wire

// ===== tb/iocm_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module iocm_mem_model (
    // clock and latency
    input wire logic         clk,
    input wire logic  [3:0]  lat,
    // memory port
    input wire logic         mem_req,
    input wire logic         mem_write,
    input wire logic  [31:0] mem_addr,
    input wire logic  [31:0] mem_wdata,
    output var logic         mem_ack,
    output wire logic [31:0] mem_rdata,
    output var logic  [31:0] wr_count
);
    reg [31:0] mem [0:1023];
    reg [31:0] rd_r, last_r;
    reg [3:0]  cnt_r;
    wire [9:0] idx = {mem_addr[24:23], mem_addr[9:2]};
    integer    k;
    initial begin
        for (k = 0; k < 1024; k = k + 1) mem[k] = 32'h0;
        mem_ack = 1'b0; cnt_r = 4'h0; rd_r = 32'h0; last_r = 32'h0; wr_count = 32'h0;
    end
    // released data line shows the inverse of the last word read
    assign mem_rdata = mem_ack ? rd_r : ~last_r;
    always @(posedge clk) begin
        if (mem_ack) begin
            mem_ack <= 1'b0; cnt_r <= 4'h0; last_r <= rd_r;
        end else if (mem_req) begin
            if (cnt_r >= lat) begin
                mem_ack <= 1'b1;
                if (mem_write) begin
                    mem[idx] <= mem_wdata; wr_count <= wr_count + 32'h1;
                end else rd_r <= mem[idx];
            end else cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== tb/io_cache_mapper_behavior_bench.sv
`timescale 1ns/100ps
`default_nettype none
module io_cache_mapper_behavior_bench;
    logic clk = 0, reset_n = 0, sys_en_we = 0, map_we = 0, map_cache_en = 0, map_wr_protect = 0;
    logic req_valid = 0, req_write = 0, req_flush = 0;
    logic [3:0] sys_en_wdata = 4'h0, lat = 4'h0;
    logic [2:0] map_sel = 3'h0;
    logic [8:0] map_xlat = 9'h0;
    logic [1:0] map_page_data_type = 2'h0;
    logic [31:0] req_addr = 32'h0, req_wdata = 32'h0;
    wire [3:0] system_enable_register;
    wire req_ready, rsp_valid_r, rsp_violation_r, mem_req_r, mem_write_r, mem_ack, busy;
    wire [31:0] rsp_rdata_r, mem_addr_r, mem_wdata_r, mem_rdata, wr_count;
    int err_count = 0, checked = 0, n, i, j, seed;
    logic [33:0] notes[$];
    logic [33:0] nt;
    logic [31:0] a_v, b_v, c_v, d_v, n0;
    logic [31:0] blk [0:7];
    iocm_core DUT (.*);
    iocm_mem_model PART (.clk(clk), .lat(lat), .mem_req(mem_req_r), .mem_write(mem_write_r),
        .mem_addr(mem_addr_r), .mem_wdata(mem_wdata_r), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .wr_count(wr_count));
    always #2 clk = ~clk;
    task close_out();
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task fail_now();
        err_count++;
        $display("unexpected at %0t: wait ran out", $time);
        close_out();
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask
    task chk_rsp(input [33:0] e);
        checked++;
        if (rsp_violation_r !== e[32] || (e[33] && !e[32] && rsp_rdata_r !== e[31:0])) begin
            err_count++;
            $display("unexpected at %0t: response %h/%b", $time, rsp_rdata_r, rsp_violation_r);
        end
    endtask
    always @(negedge clk) if (rsp_valid_r === 1'b1) begin
        if (notes.size() == 0) chk(32'h1, 32'h0);
        else begin
            nt = notes.pop_front();
            chk_rsp(nt);
        end
    end
    function [31:0] va(input [2:0] p, input [22:0] off);
        va = {6'h0, p, off};
    endfunction
    function [9:0] ix(input [2:0] p, input [22:0] off);
        ix = {p[1:0], off[9:2]};
    endfunction
    task set_en(input [3:0] v);
        @(posedge clk); sys_en_we <= 1; sys_en_wdata <= v;
        @(posedge clk); sys_en_we <= 0;
        @(negedge clk); chk({28'h0, system_enable_register}, {28'h0, v});
    endtask
    task map(input [2:0] p, input [1:0] dt, input ce, input wp);
        @(posedge clk); map_we <= 1; map_sel <= p; map_xlat <= 9'h010 + p;
        map_page_data_type <= dt; map_cache_en <= ce; map_wr_protect <= wp;
        @(posedge clk); map_we <= 0;
    endtask
    task req(input w, input f, input [31:0] a, input [31:0] d, input [33:0] e);
        notes.push_back(e);
        @(posedge clk); req_valid <= 1; req_write <= w; req_flush <= f; req_addr <= a;
        req_wdata <= d; n = 0;
        @(negedge clk);
        while (req_ready !== 1'b1) begin if (n++ > 200) fail_now(); @(negedge clk); end
        @(posedge clk); req_valid <= 0;
        while (rsp_valid_r !== 1'b1) begin if (n++ > 400) fail_now(); @(negedge clk); end
    endtask
    task rd(input [2:0] p, input [22:0] o, input [31:0] e);
        req(1'b0, 1'b0, va(p, o), 32'h0, {2'h2, e});
    endtask
    task wr(input [2:0] p, input [22:0] o, input [31:0] d);
        req(1'b1, 1'b0, va(p, o), d, 34'h0);
    endtask
    initial begin
        seed = $urandom(70875);
        repeat (6) @(posedge clk);
        reset_n <= 1;
        repeat (5) @(posedge clk);
        chk({28'h0, system_enable_register}, 32'h0);
        for (i = 0; i < 8; i++) map(i, (i == 2) ? 2'h1 : 2'h0, i != 1, i == 3);
        for (i = 0; i < 4; i++) set_en(4'h1 << i);
        chk({31'h0, req_ready}, 32'h0);
        set_en(4'h6);
        a_v = $urandom; b_v = $urandom; c_v = $urandom; d_v = $urandom;
        PART.mem[ix(0, 23'h10)] = a_v; PART.mem[ix(1, 23'h10)] = b_v;
        rd(0, 23'h10, a_v);
        PART.mem[ix(0, 23'h10)] = c_v;
        rd(1, 23'h10, b_v);
        rd(0, 23'h10, a_v);
        wr(1, 23'h10, d_v);
        chk(PART.mem[ix(1, 23'h10)], d_v);
        PART.mem[ix(1, 23'h10)] = b_v;
        rd(1, 23'h10, b_v);
        set_en(4'h4);
        rd(0, 23'h10, c_v);
        wr(0, 23'h10, d_v);
        chk(PART.mem[ix(0, 23'h10)], d_v);
        set_en(4'h6);
        rd(0, 23'h10, a_v);
        for (j = 0; j < 2; j++) begin
            set_en(j ? 4'h7 : 4'h6); lat <= j * 3;
            for (i = 0; i < 8; i++) PART.mem[ix(0, 23'h100 + j * 64 + i * 4)] = $urandom;
            for (i = 0; i < 8; i++) rd(0, 23'h100 + j * 64 + i * 4,
                PART.mem[ix(0, 23'h100 + j * 64 + i * 4)]);
        end
        n0 = wr_count;
        for (i = 0; i < 8; i++) begin blk[i] = $urandom; wr(0, 23'h200 + i * 4, blk[i]); end
        req(1'b1, 1'b1, va(0, 23'h200), 32'h0, 34'h0);
        req(1'b1, 1'b1, va(0, 23'h210), 32'h0, 34'h0);
        for (i = 0; i < 8; i++) chk(PART.mem[ix(0, 23'h200 + i * 4)], blk[i]);
        chk(wr_count, n0 + 8);
        req(1'b1, 1'b1, va(0, 23'h200), 32'h0, 34'h0);
        req(1'b1, 1'b1, va(0, 23'h100), 32'h0, 34'h0);
        chk(wr_count, n0 + 8);
        wr(3, 23'h300, $urandom);
        n0 = wr_count;
        wr(0, 23'h300, $urandom);
        chk(wr_count, n0);
        req(1'b0, 1'b0, va(2, 23'h40), 32'h0, {2'h3, 32'h0});
        repeat (2) @(posedge clk);
        chk(notes.size(), 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
